// File: include/qmver_pkg.sv
// package of offsets, field layouts and reset values for the queue
// mapping and vlan entry staging registers.
// assumes a single switch core clock and byte addressed registers.
package qmver_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [15:0] QMC_OFS = 16'h0390;
  localparam logic [15:0] VE0_OFS = 16'h0400;
  localparam logic [15:0] VIDX_OFS = 16'h040C;
  localparam logic [15:0] VACC_OFS = 16'h040E;

  // ****************************************
  // queue management control layout
  // ****************************************
  localparam int QMC_SPLIT_LSB = 6;
  localparam int QMC_DISCARD_BIT = 1;
  localparam logic [7:0] QMC_RESET = 8'h82;
  localparam logic [1:0] SPLIT_HI3 = 2'h0;
  localparam logic [1:0] SPLIT_HI23 = 2'h2;
  localparam logic [1:0] SPLIT_HI123 = 2'h3;

  // ****************************************
  // vlan entry word zero layout
  // ****************************************
  localparam int VE0_VALID_BIT = 31;
  localparam int VE0_FWD_OPT_BIT = 27;
  localparam int VE0_PRIO_LSB = 24;
  localparam int VE0_MSTI_LSB = 12;
  localparam int VE0_FGID_LSB = 0;
  localparam logic [31:0] VE0_MASK = 32'h8F00707F;
  localparam logic [31:0] VE0_RESET = 32'h00000000;

  // ****************************************
  // vlan table access
  // ****************************************
  localparam int VIDX_W = 12;
  localparam int TBL_DEPTH = 4096;
  localparam logic [11:0] VIDX_RESET = 12'h000;
  localparam logic [11:0] TBL_LAST = 12'hFFF;
  localparam int VACC_START_BIT = 7;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_WRITE = 2'h1,
    ACT_READ = 2'h2,
    ACT_CLEAR = 2'h3
  } qmver_act_t;

endpackage

// File: include/qmver_tbl_if.sv
// request and answer path between the register bank and the vlan table.
// assumes both ends run on the same clock and clock enable.
`timescale 1ns/10ps
interface qmver_tbl_if;
  logic req;
  logic [1:0] action;
  logic [11:0] index;
  logic [31:0] wdata;
  logic done;
  logic [31:0] rdata;
  logic [11:0] lk_vid;
  logic [31:0] lk_entry;

  modport ctl (output req, action, index, wdata, lk_vid,
               input done, rdata, lk_entry);
  modport tbl (input req, action, index, wdata, lk_vid,
               output done, rdata, lk_entry);
endinterface

// File: hw/qmver_vlan_table.sv
// vlan table storage: entry word zero for every vlan index, with write,
// read and clear-all operations and a registered lookup port.
// assumes the requester keeps one operation in flight at a time.
`timescale 1ns/10ps
module qmver_vlan_table
  import qmver_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  qmver_tbl_if.tbl tbl
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    TBL_IDLE = 2'b01,
    TBL_CLEAR = 2'b10
  } qmver_tbl_fsm_t;

  typedef struct packed {
    qmver_tbl_fsm_t fsm;
    logic [11:0] cidx;
    logic done;
    logic [31:0] rdata;
    logic [31:0] lk;
  } qmver_tbl_state_t;

  qmver_tbl_state_t st_r;
  qmver_tbl_state_t st_nxt;
  logic [31:0] mem [TBL_DEPTH];
  logic we;
  logic [11:0] we_addr;
  logic [31:0] we_data;

  // next state and table write port
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    we = 1'b0;
    we_addr = tbl.index;
    we_data = tbl.wdata & VE0_MASK;
    st_nxt.lk = mem[tbl.lk_vid];
    case (st_r.fsm)
      TBL_IDLE: begin
        if (tbl.req) begin
          case (qmver_act_t'(tbl.action))
            ACT_WRITE: begin
              we = 1'b1; // RULE_16
              st_nxt.done = 1'b1;
            end
            ACT_READ: begin
              st_nxt.rdata = mem[tbl.index];
              st_nxt.done = 1'b1;
            end
            ACT_CLEAR: begin
              st_nxt.fsm = TBL_CLEAR;
              st_nxt.cidx = 12'h000;
            end
            default: begin
              st_nxt.done = 1'b1;
            end
          endcase
        end
      end
      TBL_CLEAR: begin
        // one entry zeroed per cycle
        we = 1'b1;
        we_addr = st_r.cidx;
        we_data = 32'h00000000;
        st_nxt.cidx = st_r.cidx + 12'h001;
        if (st_r.cidx == TBL_LAST) begin
          st_nxt.fsm = TBL_IDLE;
          st_nxt.done = 1'b1; // RULE_13
        end
      end
      default: begin
        st_nxt.fsm = TBL_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '{fsm: TBL_IDLE, cidx: 12'h000, done: 1'b0,
                rdata: 32'h00000000, lk: 32'h00000000};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // table array, no reset
  always_ff @(posedge i_clk) begin
    if (i_ce && we) begin
      mem[we_addr] <= we_data;
    end
  end

  assign tbl.done = st_r.done;
  assign tbl.rdata = st_r.rdata;
  assign tbl.lk_entry = st_r.lk;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_table_write_cause: assert property ( // RULE_16
    (i_ce && we) |-> (st_r.fsm == TBL_CLEAR) ||
      (tbl.req && tbl.action == ACT_WRITE))
    else $error("table written without write or clear operation");

  a_clear_from_zero: assert property ( // RULE_13
    (i_ce && st_r.fsm == TBL_IDLE && tbl.req && tbl.action == ACT_CLEAR)
      |=> (st_r.fsm == TBL_CLEAR && st_r.cidx == 12'h000))
    else $error("clear-all did not start at index zero");

endmodule

// File: hw/qmver_top.sv
// global queue mapping control and vlan entry staging registers of a
// three-port switch, with the vlan table access sequencing they drive.
// assumes the management interface logic presents one register access
// per cycle on the core clock, and frame decisions arrive on that clock.
//
// Overview of operation
// RULE_01: the two-queue split is applied only when the port uses two queues.
// RULE_02: split code 00 puts only priority 3 high, code 11 puts 1 to 3 high.
// RULE_03: split resets to 10 (priorities 2 and 3 high); code 01 is unused.
// RULE_04: with the discard bit set every frame is limited to member ports.
// RULE_05: with the discard bit clear single-destination frames skip it.
// RULE_06: with discard clear, a mirrored single-destination frame is dropped.
// RULE_07: entry bit 31 marks the entry valid and resets to zero.
// RULE_08: with the forward option set, the vlan entry port map is used.
// RULE_09: with the forward option clear, ports come from other sources.
// RULE_10: entry bits 26:24 hold the vlan priority, resetting to zero.
// RULE_11: entry bits 14:12 hold the spanning tree instance index.
// RULE_12: entry bits 6:0 hold the filter id used to hash the lookup table.
// RULE_13: an action code plus start bit runs a table op; start self-clears.
// RULE_14: a 12-bit index selects the table entry written or read.
// RULE_15: reserved bits of the entry staging word always read as zero.
// RULE_16: staging writes alter no table entry until a write op is issued.
`timescale 1ns/10ps
module qmver_top
  import qmver_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_two_queue_mode,
  input wire logic [1:0] i_regen_prio,
  output logic o_high_queue,
  input wire logic [2:0] i_dest_map,
  input wire logic [2:0] i_member_map,
  input wire logic i_mirror_active,
  input wire logic i_mirrored,
  output logic [2:0] o_fwd_map,
  output logic o_drop,
  input wire logic [11:0] i_lookup_vid,
  output logic o_vlan_valid,
  output logic o_use_vlan_map,
  output logic [2:0] o_vlan_prio,
  output logic [2:0] o_spanning_instance_index,
  output logic [6:0] o_filter_group_id,
  output logic o_table_busy
);

  // ****************************************
  // state and helpers
  // ****************************************
  typedef struct packed {
    logic [7:0] qmc;
    logic [31:0] ve0;
    logic [11:0] vidx;
    logic [1:0] act;
    logic start;
    logic req;
    logic [31:0] rdata;
    logic [2:0] fwd;
    logic drop;
    logic high;
  } qmver_top_state_t;

  qmver_top_state_t st_r;
  qmver_top_state_t st_nxt;
  qmver_tbl_if tif ();
  logic [1:0] split;
  logic discard;
  logic single;
  logic wr_ok;

  // high queue decision from 2-bit priority and split code
  function automatic logic split_high(input logic [1:0] code,
                                      input logic [1:0] prio);
    logic hi;
    hi = 1'b0;
    if (code == SPLIT_HI3) begin
      hi = (prio == 2'h3);
    end else if (code == SPLIT_HI123) begin
      hi = (prio != 2'h0);
    end else begin
      // unused code behaves as the default split
      hi = prio[1];
    end
    return hi;
  endfunction

  // exactly one destination port
  function automatic logic one_hot3(input logic [2:0] m);
    return (m == 3'h1) || (m == 3'h2) || (m == 3'h4);
  endfunction

  assign split = st_r.qmc[QMC_SPLIT_LSB +: 2];
  assign discard = st_r.qmc[QMC_DISCARD_BIT];
  assign single = one_hot3(i_dest_map);
  // writes to the staging, index and access registers are held off while an op runs; queue control writes are not
  assign wr_ok = i_reg_wr && !st_r.start;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.req = 1'b0;

    // register writes
    if (i_reg_addr == QMC_OFS && i_reg_wr) begin
      st_nxt.qmc = i_reg_wdata[7:0];
    end else if (i_reg_addr == VE0_OFS && wr_ok) begin
      st_nxt.ve0 = i_reg_wdata & VE0_MASK; // RULE_15
    end else if (i_reg_addr == VIDX_OFS && wr_ok) begin
      st_nxt.vidx = i_reg_wdata[VIDX_W-1:0]; // RULE_14
    end else if (i_reg_addr == VACC_OFS && wr_ok) begin
      st_nxt.act = i_reg_wdata[1:0];
      st_nxt.start = i_reg_wdata[VACC_START_BIT]; // RULE_13
      st_nxt.req = i_reg_wdata[VACC_START_BIT];
    end

    // completion of a table operation
    if (tif.done) begin
      st_nxt.start = 1'b0; // RULE_13
      if (st_r.act == ACT_READ) begin
        st_nxt.ve0 = tif.rdata & VE0_MASK;
      end
    end

    // register reads, unmapped addresses read zero
    if (i_reg_rd) begin
      if (i_reg_addr == QMC_OFS) begin
        st_nxt.rdata = {24'h000000, st_r.qmc};
      end else if (i_reg_addr == VE0_OFS) begin
        st_nxt.rdata = st_r.ve0 & VE0_MASK; // RULE_15
      end else if (i_reg_addr == VIDX_OFS) begin
        st_nxt.rdata = {20'h00000, st_r.vidx};
      end else if (i_reg_addr == VACC_OFS) begin
        st_nxt.rdata = {24'h000000, st_r.start, 5'h00, st_r.act};
      end else begin
        st_nxt.rdata = 32'h00000000;
      end
    end

    // queue split only under two-queue mode
    st_nxt.high = i_two_queue_mode && // RULE_01
      split_high(split, i_regen_prio); // RULE_02

    // membership restriction and mirror drop
    if (discard) begin
      st_nxt.fwd = i_dest_map & i_member_map; // RULE_04
      st_nxt.drop = 1'b0;
    end else if (single) begin
      st_nxt.fwd = i_dest_map; // RULE_05
      st_nxt.drop = i_mirror_active && i_mirrored; // RULE_06
    end else begin
      st_nxt.fwd = i_dest_map & i_member_map;
      st_nxt.drop = 1'b0;
    end
  end

  // state register, reset values of the documented fields
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '{qmc: QMC_RESET, // RULE_03
                ve0: VE0_RESET, // RULE_07 RULE_10
                vidx: VIDX_RESET, act: ACT_NONE, start: 1'b0,
                req: 1'b0, rdata: 32'h00000000, fwd: 3'h0,
                drop: 1'b0, high: 1'b0};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // vlan table
  // ****************************************
  assign tif.req = st_r.req;
  assign tif.action = st_r.act;
  assign tif.index = st_r.vidx; // RULE_14
  assign tif.wdata = st_r.ve0;
  assign tif.lk_vid = i_lookup_vid;

  qmver_vlan_table u_table (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .tbl(tif)
  );

  // outputs
  assign o_reg_rdata = st_r.rdata;
  assign o_high_queue = st_r.high;
  assign o_fwd_map = st_r.fwd;
  assign o_drop = st_r.drop;
  assign o_table_busy = st_r.start;
  assign o_vlan_valid = tif.lk_entry[VE0_VALID_BIT]; // RULE_07
  // vlan map when entry valid and option set, other sources otherwise
  assign o_use_vlan_map = tif.lk_entry[VE0_VALID_BIT] &&
    tif.lk_entry[VE0_FWD_OPT_BIT]; // RULE_08 RULE_09
  assign o_vlan_prio = tif.lk_entry[VE0_PRIO_LSB +: 3]; // RULE_10
  assign o_spanning_instance_index =
    tif.lk_entry[VE0_MSTI_LSB +: 3]; // RULE_11
  assign o_filter_group_id = tif.lk_entry[VE0_FGID_LSB +: 7]; // RULE_12

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_split_code_zero: assert property ( // RULE_02
    (i_ce && i_two_queue_mode && split == SPLIT_HI3 && i_regen_prio == 2'h2)
      |=> !o_high_queue)
    else $error("priority 2 went high under split code 00");

  a_split_default_map: assert property ( // RULE_03
    (i_ce && i_two_queue_mode && split == SPLIT_HI23)
      |=> (o_high_queue == $past(i_regen_prio[1])))
    else $error("default split did not map 2 and 3 high");

  a_single_queue_low: assert property ( // RULE_01
    (i_ce && !i_two_queue_mode) |=> !o_high_queue)
    else $error("high queue used outside two-queue mode");

  a_member_confine: assert property ( // RULE_04
    (i_ce && discard) |=> (!o_drop &&
      o_fwd_map == ($past(i_dest_map) & $past(i_member_map))))
    else $error("frame escaped membership restriction");

  a_single_bypass: assert property ( // RULE_05
    (i_ce && !discard && single) |=> (o_fwd_map == $past(i_dest_map)))
    else $error("single destination frame was restricted");

  a_mirror_drop: assert property ( // RULE_06
    (i_ce && !discard && single && i_mirror_active && i_mirrored)
      |=> o_drop)
    else $error("mirrored single destination frame not dropped");

  a_reserved_zero: assert property ( // RULE_15
    (i_ce && i_reg_rd && i_reg_addr == VE0_OFS)
      |=> ((o_reg_rdata & ~VE0_MASK) == 32'h00000000))
    else $error("reserved entry bits read nonzero");

  a_index_write: assert property ( // RULE_14
    (i_ce && wr_ok && i_reg_addr == VIDX_OFS)
      |=> (st_r.vidx == $past(i_reg_wdata[11:0])))
    else $error("vlan index not updated by write");

  sequence s_launch_write;
    i_ce && wr_ok && i_reg_addr == VACC_OFS &&
      i_reg_wdata[VACC_START_BIT] && i_reg_wdata[1:0] == ACT_WRITE;
  endsequence

  sequence s_start_seen;
    o_table_busy && st_r.req;
  endsequence

  a_start_self_clear: assert property ( // RULE_13
    s_launch_write ##1 s_start_seen |-> ##[1:40] !o_table_busy)
    else $error("start bit did not clear after write operation");

endmodule

// File: tb/qmver_top_tb_top.sv
// self-checking bench for the queue mapping and vlan entry registers.
// assumes inputs driven at the falling edge of a 25 MHz core clock.
`timescale 1ns/10ps
module qmver_top_tb_top;
  import qmver_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdat;
  logic tq = 1'b0;
  logic [1:0] pr = 2'h0;
  logic hq;
  logic [2:0] dm = 3'h0;
  logic [2:0] mm = 3'h0;
  logic ma = 1'b0;
  logic mr = 1'b0;
  logic [2:0] fm;
  logic drop;
  logic [11:0] vid = 12'h000;
  logic vv;
  logic uvm;
  logic [2:0] vp;
  logic [2:0] msti;
  logic [6:0] fgid;
  logic busy;
  int errors = 0;
  int samples_checked = 0;

  // ****************************************
  // clock and design
  // ****************************************
  always #20 i_clk = ~i_clk;

  qmver_top u_qmver_top (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd),
    .i_reg_rd(rd), .o_reg_rdata(rdat),
    .i_two_queue_mode(tq), .i_regen_prio(pr), .o_high_queue(hq),
    .i_dest_map(dm), .i_member_map(mm), .i_mirror_active(ma),
    .i_mirrored(mr), .o_fwd_map(fm), .o_drop(drop),
    .i_lookup_vid(vid), .o_vlan_valid(vv), .o_use_vlan_map(uvm),
    .o_vlan_prio(vp), .o_spanning_instance_index(msti),
    .o_filter_group_id(fgid), .o_table_busy(busy)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // compare one value, count it and report a mismatch
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  // one-cycle write strobe
  task automatic wreg(input logic [15:0] a, input logic [31:0] d);
    @(negedge i_clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge i_clk);
    wr = 1'b0;
  endtask

  // one-cycle read strobe, data checked the cycle after
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    @(negedge i_clk);
    addr = a;
    rd = 1'b1;
    @(negedge i_clk);
    rd = 1'b0;
    chk("reg_rdata", e, rdat);
  endtask

  // launch a table op, then wait for busy to drop, bounded
  task automatic tbl_op(input logic [1:0] act);
    int n;
    wreg(VACC_OFS, {24'h000000, 1'b1, 5'h00, act});
    chk("table_busy", 32'h1, {31'h0, busy});
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 5000) begin
      errors++;
      close_out();
    end
  endtask

  // frame path: inputs at one edge, outputs after it
  task automatic frame(input logic t, input logic [1:0] p,
                       input logic [2:0] d, input logic [2:0] m,
                       input logic a, input logic r, input logic eh,
                       input logic [2:0] ef, input logic ed);
    @(negedge i_clk);
    tq = t;
    pr = p;
    dm = d;
    mm = m;
    ma = a;
    mr = r;
    @(negedge i_clk);
    chk("high_queue", {31'h0, eh}, {31'h0, hq});
    chk("drop", {31'h0, ed}, {31'h0, drop});
    if (!ed) chk("fwd_map", {29'h0, ef}, {29'h0, fm});
  endtask

  // lookup fields of entry v after the read latency
  task automatic look(input logic [11:0] v, input logic [14:0] e);
    @(negedge i_clk);
    vid = v;
    repeat (3) @(negedge i_clk);
    chk("lookup", {17'h0, e}, {17'h0, vv, uvm, vp, msti, fgid});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rchk(QMC_OFS, 32'h00000082);
    rchk(VE0_OFS, 32'h00000000);
    rchk(VIDX_OFS, 32'h00000000);
    rchk(VACC_OFS, 32'h00000000);
    rchk(16'h0500, 32'h00000000);
  endtask

  // split codes 10, 00 and 11 against every priority, and single-queue ports
  task automatic t_split();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      frame(1'b1, i[1:0], 3'h0, 3'h0, 1'b0, 1'b0, i >= 2,
            3'h0, 1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      c = (k == 0) ? SPLIT_HI3 : SPLIT_HI123;
      wreg(QMC_OFS, {24'h0, c, 6'h02});
      for (int i = 0; i < 4; i++) begin
        frame(1'b1, i[1:0], 3'h0, 3'h0, 1'b0, 1'b0,
              (k == 0) ? (i == 3) : (i >= 1), 3'h0, 1'b0);
      end
    end
    frame(1'b0, 2'h3, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
    wreg(QMC_OFS, 32'h00000082);
  endtask

  // membership limit with the discard bit set, then cleared
  task automatic t_member();
    frame(1'b0, 2'h0, 3'h1, 3'h6, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
    frame(1'b0, 2'h0, 3'h3, 3'h2, 1'b0, 1'b0, 1'b0, 3'h2, 1'b0);
    wreg(QMC_OFS, 32'h000000BC);
    rchk(QMC_OFS, 32'h000000BC);
    frame(1'b0, 2'h0, 3'h1, 3'h6, 1'b0, 1'b0, 1'b0, 3'h1, 1'b0);
    frame(1'b0, 2'h0, 3'h1, 3'h6, 1'b1, 1'b0, 1'b0, 3'h1, 1'b0);
    frame(1'b0, 2'h0, 3'h1, 3'h6, 1'b1, 1'b1, 1'b0, 3'h0, 1'b1);
    frame(1'b0, 2'h0, 3'h4, 3'h3, 1'b1, 1'b1, 1'b0, 3'h4, 1'b1);
    wreg(QMC_OFS, 32'h00000082);
  endtask

  // staging word mask, clear, write, read and no-op table actions
  task automatic t_entry();
    wreg(VE0_OFS, 32'hFFFFFFFF);
    rchk(VE0_OFS, 32'h8F00707F);
    tbl_op(ACT_CLEAR);
    look(12'hFFF, 15'h0000);
    wreg(VIDX_OFS, 32'h00000005);
    rchk(VIDX_OFS, 32'h00000005);
    wreg(VE0_OFS, 32'h8A00506B);
    look(12'h005, 15'h0000);
    tbl_op(ACT_WRITE);
    look(12'h005, {1'b1, 1'b1, 3'h2, 3'h5, 7'h6B});
    wreg(VIDX_OFS, 32'h00000006);
    wreg(VE0_OFS, 32'h81001001);
    tbl_op(ACT_WRITE);
    look(12'h006, {1'b1, 1'b0, 3'h1, 3'h1, 7'h01});
    look(12'h005, {1'b1, 1'b1, 3'h2, 3'h5, 7'h6B});
    wreg(VE0_OFS, 32'h00000000);
    tbl_op(ACT_NONE);
    look(12'h006, {1'b1, 1'b0, 3'h1, 3'h1, 7'h01});
    wreg(VIDX_OFS, 32'h00000005);
    tbl_op(ACT_READ);
    rchk(VE0_OFS, 32'h8A00506B);
    rchk(VACC_OFS, 32'h00000002);
  endtask

  // clock enable low freezes writes, mid-run reset restores defaults
  task automatic t_hold();
    wreg(QMC_OFS, 32'h00000000);
    wreg(VIDX_OFS, 32'h00000009);
    ce = 1'b0;
    wreg(QMC_OFS, 32'h000000C2);
    ce = 1'b1;
    rchk(QMC_OFS, 32'h00000000);
    @(negedge i_clk);
    i_nrst = 1'b0;
    @(negedge i_clk);
    chk("table_busy", 32'h0, {31'h0, busy});
    chk("drop", 32'h0, {31'h0, drop});
    chk("fwd_map", 32'h0, {29'h0, fm});
    chk("high_queue", 32'h0, {31'h0, hq});
    i_nrst = 1'b1;
    rchk(QMC_OFS, 32'h00000082);
    rchk(VIDX_OFS, 32'h00000000);
    rchk(VE0_OFS, 32'h00000000);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(negedge i_clk);
    i_nrst = 1'b1;
    t_reset();
    t_split();
    t_member();
    t_entry();
    t_hold();
    close_out();
  end
endmodule
